/* File: lfa_core.sv */
// execution datapath for add/and literal, add/and file and bit clear
`timescale 1ns/1ps
`include "lfa_cfg.svh"
module lfa_core (
   input  wire logic                 sys_clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 instr_valid_i,
   input  wire logic [13:0]          instr_i,
   input  wire logic [7:0]           file_rdata_i,
   input  wire lfa_pkg::lfa_flags_t  flags_i,
   output logic      [6:0]           file_addr_o,
   output lfa_pkg::lfa_fwr_t         file_wr_o,
   output logic      [7:0]           acc_o,
   output lfa_pkg::lfa_flags_t       flags_o,
   output logic                      flags_we_o,
   output logic                      done_o,
   output logic                      busy_o
);
   // one instruction cycle is four clock phases; the next fetch sits at phase 3, the last
   logic [1:0]          phase_r;
   logic [13:0]         ir_r;
   logic                run_r;
   logic [7:0]          acc_r;
   logic [7:0]          acc_nxt;
   lfa_pkg::lfa_flags_t flg_r;
   lfa_pkg::lfa_flags_t flg_nxt;
   lfa_pkg::lfa_fwr_t   fwr_r;
   lfa_pkg::lfa_fwr_t   fwr_nxt;
   logic                fwe_r;
   logic                done_r;

   function automatic lfa_pkg::lfa_op_t decode(input logic [13:0] ir);
      if (ir[`LFA_OP_HI:`LFA_OP_LO+1] == `LFA_OP_ADDLIT_TOP)
         decode = lfa_pkg::LFA_ADDLIT;
      else if (ir[`LFA_OP_HI:`LFA_OP_LO] == `LFA_OP_ANDLIT)
         decode = lfa_pkg::LFA_ANDLIT;
      else if (ir[`LFA_OP_HI:`LFA_OP_LO] == `LFA_OP_ADDFILE)
         decode = lfa_pkg::LFA_ADDFILE;
      else if (ir[`LFA_OP_HI:`LFA_OP_LO] == `LFA_OP_ANDFILE)
         decode = lfa_pkg::LFA_ANDFILE;
      else if (ir[`LFA_BCF_HI:`LFA_BCF_LO] == `LFA_BCF_CODE)
         decode = lfa_pkg::LFA_CLRBIT;
      else
         decode = lfa_pkg::LFA_NONE;
   endfunction

   // one-hot mask of the bit to clear
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = `LFA_BIT_ONE << b;
   endfunction

   wire lfa_pkg::lfa_op_t op_w   = decode(ir_r);
   wire logic             dest_w = ir_r[`LFA_DEST_BIT];
   wire logic [7:0]       lit_w  = ir_r[`LFA_LIT_HI:0];
   wire logic [2:0]       bsel_w = ir_r[`LFA_BIT_HI:`LFA_BIT_LO];
   wire logic [6:0]       fadr_w = ir_r[`LFA_ADDR_HI:0];
   wire logic             is_lit = (op_w == lfa_pkg::LFA_ADDLIT) || (op_w == lfa_pkg::LFA_ANDLIT);
   wire logic             is_and = (op_w == lfa_pkg::LFA_ANDLIT) || (op_w == lfa_pkg::LFA_ANDFILE);
   wire logic             is_add = (op_w == lfa_pkg::LFA_ADDLIT) || (op_w == lfa_pkg::LFA_ADDFILE);
   wire logic             is_fop = (op_w == lfa_pkg::LFA_ADDFILE) || (op_w == lfa_pkg::LFA_ANDFILE);
   wire logic             last_w = run_r && (phase_r == `LFA_PH_LAST);
   wire logic [7:0]       opb_w  = is_lit ? lit_w : file_rdata_i;
   wire logic [7:0]       clr_w  = file_rdata_i & ~bit_mask(bsel_w);

   logic [7:0]          alu_res;
   lfa_pkg::lfa_flags_t alu_flg;

   lfa_alu u_alu (
      .do_and_i (is_and),
      .a_i      (acc_r),
      .b_i      (opb_w),
      .res_o    (alu_res),
      .flags_o  (alu_flg)
   );

   always_comb begin
      acc_nxt = acc_r;
      flg_nxt = flags_i;
      fwr_nxt = '0;
      fwr_nxt.addr = fadr_w;
      if (last_w) begin
         if (is_lit || (is_fop && !dest_w))
            acc_nxt = alu_res;
         if (is_fop && dest_w) begin
            fwr_nxt.we   = 1'b1;
            fwr_nxt.data = alu_res;
         end
         if (op_w == lfa_pkg::LFA_CLRBIT) begin
            fwr_nxt.we   = 1'b1;
            fwr_nxt.data = clr_w;
         end
         if (is_add)
            flg_nxt = alu_flg;
         if (is_and)
            flg_nxt.z = alu_flg.z;
      end
   end

   // instruction latch; words offered while busy are refused until the last phase
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         phase_r <= `LFA_PH_FIRST;
         run_r   <= 1'b0;
         ir_r    <= `LFA_IR_RST;
      end else if (!run_r || last_w) begin
         run_r   <= instr_valid_i;
         ir_r    <= instr_i;
         phase_r <= `LFA_PH_FIRST;
      end else begin
         phase_r <= phase_r + `LFA_PH_STEP;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_r  <= `LFA_ACC_RST;
         flg_r  <= '0;
         fwr_r  <= '0;
         fwe_r  <= 1'b0;
         done_r <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         flg_r  <= flg_nxt;
         fwr_r  <= fwr_nxt;
         fwe_r  <= last_w && (is_add || is_and);
         done_r <= last_w;
      end
   end

   // file read is combinational on the address held through the cycle
   assign file_addr_o = fadr_w;
   assign file_wr_o   = fwr_r;
   assign acc_o       = acc_r;
   assign flags_o     = flg_r;
   assign flags_we_o  = fwe_r;
   assign done_o      = done_r;
   assign busy_o      = run_r;

   a_add_lit_acc: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ADDLIT |=> acc_r == $past(acc_r + lit_w) && flags_we_o)
      else $error("add literal result wrong");
   a_and_lit_acc: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ANDLIT |=> acc_r == $past(acc_r & lit_w)
      && flags_o.c == $past(flags_i.c) && flags_o.dc == $past(flags_i.dc))
      else $error("and literal result or flags wrong");
   a_add_file_sum: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ADDFILE && dest_w |=> file_wr_o.we
      && file_wr_o.data == $past(acc_r + file_rdata_i))
      else $error("add file write back wrong");
   a_dest_acc_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && is_fop && dest_w |=> $stable(acc_r))
      else $error("accumulator changed on file destination");
   a_dest_acc_wr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && is_fop && !dest_w |=> !file_wr_o.we && acc_r == $past(alu_res))
      else $error("accumulator destination wrong");
   a_and_file_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ANDFILE |=> flags_o.z == ($past(acc_r & file_rdata_i) == 8'h00))
      else $error("and file zero flag wrong");
   a_clr_bit_only: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_CLRBIT |=> file_wr_o.we && !flags_we_o
      && file_wr_o.data[$past(bsel_w)] == 1'b0 && $stable(acc_r))
      else $error("bit clear wrong");
   a_cycle_four: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      done_o && busy_o |=> !done_o ##1 !done_o ##1 !done_o ##1 done_o)
      else $error("instruction cycle not four clocks");
   a_carry_digit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && is_add |=> flags_o.c == $past(({1'b0, acc_r} + {1'b0, opb_w}) > 9'h0ff)
      && flags_o.dc == $past((acc_r[3:0] + opb_w[3:0]) > 5'h0f))
      else $error("carry or digit carry wrong");

   // flag handling of the and ops, the zero flag of adds and the bits kept by bit clear
   a_and_lit_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ANDLIT |=> flags_we_o && flags_o.z == ($past(acc_r & lit_w) == 8'h00))
      else $error("and literal zero flag wrong");
   a_and_file_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_ANDFILE |=> flags_we_o
      && flags_o.c == $past(flags_i.c) && flags_o.dc == $past(flags_i.dc))
      else $error("and file touched carry flags");
   a_add_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && is_add |=> flags_o.z == ($past(acc_r + opb_w) == 8'h00))
      else $error("add zero flag wrong");
   a_clr_bit_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_CLRBIT |=> (file_wr_o.data | bit_mask($past(bsel_w)))
      == ($past(file_rdata_i) | bit_mask($past(bsel_w))) && file_wr_o.addr == $past(fadr_w))
      else $error("bit clear disturbed other bits");

   // sequencing: unknown words, refusal while busy, one-cycle strobes
   a_unknown_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && op_w == lfa_pkg::LFA_NONE |=> !file_wr_o.we && !flags_we_o && $stable(acc_r))
      else $error("unknown opcode wrote state");
   a_ir_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      run_r && !last_w |=> $stable(ir_r))
      else $error("instruction taken while busy");
   a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      done_o |=> !done_o)
      else $error("done longer than one cycle");
   a_fwr_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      file_wr_o.we |=> !file_wr_o.we)
      else $error("file write longer than one cycle");
   a_dest_file_wr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && is_fop && dest_w |=> file_wr_o.we && file_wr_o.addr == $past(fadr_w))
      else $error("file destination write missing");
   a_busy_level: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      last_w && !instr_valid_i |=> !busy_o)
      else $error("busy without a new instruction");

   c_add_lit:  cover property (@(posedge sys_clk_i) last_w && op_w == lfa_pkg::LFA_ADDLIT && alu_flg.c);
   c_and_file: cover property (@(posedge sys_clk_i) last_w && op_w == lfa_pkg::LFA_ANDFILE && dest_w);
   c_clr_bit:  cover property (@(posedge sys_clk_i) last_w && op_w == lfa_pkg::LFA_CLRBIT);
   c_back2bk:  cover property (@(posedge sys_clk_i) done_o ##4 done_o);
   c_dest_acc: cover property (@(posedge sys_clk_i) last_w && is_fop && !dest_w);
endmodule

/* File: lfa_cfg.svh */
// constants for the literal and file alu datapath
`ifndef LFA_CFG_SVH
`define LFA_CFG_SVH
`define LFA_OP_HI       13
`define LFA_OP_LO       8
`define LFA_OP_ADDLIT   6'h3e
`define LFA_OP_ADDLIT_TOP 5'h1f
`define LFA_LIT_HI      7
`define LFA_BIT_ONE     8'h01
`define LFA_PH_FIRST    2'h0
`define LFA_PH_STEP     2'h1
`define LFA_IR_RST      14'h0000
`define LFA_OP_ANDLIT   6'h39
`define LFA_OP_ADDFILE  6'h07
`define LFA_OP_ANDFILE  6'h05
`define LFA_BCF_HI      13
`define LFA_BCF_LO      10
`define LFA_BCF_CODE    4'h4
`define LFA_DEST_BIT    7
`define LFA_ADDR_HI     6
`define LFA_BIT_HI      9
`define LFA_BIT_LO      7
`define LFA_PHASES      4
`define LFA_PH_LAST     2'h3
`define LFA_ACC_RST     8'h00
`define LFA_NIB_HI      3
`endif

/* File: lfa_pkg.sv */
// types for the literal and file alu datapath
package lfa_pkg;
   typedef enum logic [2:0] {
      LFA_NONE,
      LFA_ADDLIT,
      LFA_ANDLIT,
      LFA_ADDFILE,
      LFA_ANDFILE,
      LFA_CLRBIT
   } lfa_op_t;

   typedef struct packed {
      logic c;
      logic dc;
      logic z;
   } lfa_flags_t;

   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } lfa_fwr_t;
endpackage

/* File: lfa_alu.sv */
// combinational add and and unit with carry, digit carry and zero
`timescale 1ns/1ps
`include "lfa_cfg.svh"
module lfa_alu (
   input  wire logic             do_and_i,
   input  wire logic [7:0]       a_i,
   input  wire logic [7:0]       b_i,
   output logic      [7:0]       res_o,
   output lfa_pkg::lfa_flags_t   flags_o
);
   wire logic [8:0] sum_w = {1'b0, a_i} + {1'b0, b_i};
   wire logic [4:0] nib_w = {1'b0, a_i[`LFA_NIB_HI:0]} + {1'b0, b_i[`LFA_NIB_HI:0]};
   assign res_o      = do_and_i ? (a_i & b_i) : sum_w[7:0];
   // one driver for the whole flag struct keeps strict tools happy
   assign flags_o = '{c: sum_w[8], dc: nib_w[4], z: (res_o == 8'h00)};
endmodule

/* File: literal_file_alu_ops_test.sv */
// self-checking random testbench for the literal and file alu datapath
`timescale 1ns/1ps
module literal_file_alu_ops_test;
   logic                sys_clk_i, resetn_i, instr_valid_i, efw, b2b;
   logic [13:0]         instr_i, cur;
   logic [7:0]          fmem [128];
   logic [7:0]          acc_o, acc_m, ea;
   logic [6:0]          file_addr_o;
   logic                flags_we_o, done_o, busy_o;
   lfa_pkg::lfa_flags_t flg, ef, flags_o;
   lfa_pkg::lfa_fwr_t   ew, file_wr_o;
   logic [31:0]         rnd = 32'h7b25;
   int                  num_errors = 0;
   int                  tests_run = 0;
   // carry, digit carry and zero corners, file destination for add and and, bit 7 clear, unknown op
   logic [13:0]         corner [8] = '{14'h3e10, 14'h3e15, 14'h3fdb, 14'h3900,
                                       14'h07ff, 14'h1380, 14'h0580, 14'h2a55};

   lfa_core dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
                 .instr_i(instr_i), .file_rdata_i(fmem[file_addr_o]), .flags_i(flg),
                 .file_addr_o(file_addr_o), .file_wr_o(file_wr_o), .acc_o(acc_o), .flags_o(flags_o),
                 .flags_we_o(flags_we_o), .done_o(done_o), .busy_o(busy_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   // file memory follows the write strobe, as the register file would
   always @(posedge sys_clk_i) if (file_wr_o.we === 1'b1) fmem[file_wr_o.addr] <= file_wr_o.data;

   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [13:0] pick(input int i, input logic [31:0] r);
      if (i < 8) return corner[i];
      case (r[18:16])
         3'h0: return {5'h1f, r[8:0]};
         3'h1: return {6'h39, r[7:0]};
         3'h2, 3'h5: return {6'h07, r[7:0]};
         3'h3: return {6'h05, r[7:0]};
         3'h4, 3'h6: return {4'h4, r[9:0]};
         default: return {6'h2a, r[7:0]};
      endcase
   endfunction

   // reference result worked out from the model's accumulator, memory and flags
   task automatic expect_op(input logic [13:0] ins);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] op, r;
      logic       isadd, isand, tofile;
      op = ins[13] ? ins[7:0] : fmem[ins[6:0]];
      isadd = (ins[13:9] == 5'h1f) || (ins[13:8] == 6'h07);
      isand = (ins[13:8] == 6'h39) || (ins[13:8] == 6'h05);
      tofile = !ins[13] && (isadd || isand) && ins[7];
      s = {1'b0, acc_m} + {1'b0, op};
      h = {1'b0, acc_m[3:0]} + {1'b0, op[3:0]};
      r = isadd ? s[7:0] : (acc_m & op);
      ef = flg;
      if (isadd) ef = '{c: s[8], dc: h[4], z: (r == 8'h00)};
      if (isand) ef.z = (r == 8'h00);
      efw = isadd || isand;
      ea = (efw && !tofile) ? r : acc_m;
      ew = '0;
      if (tofile) ew = '{we: 1'b1, addr: ins[6:0], data: r};
      if (ins[13:10] == 4'h4) ew = '{we: 1'b1, addr: ins[6:0], data: op & ~(8'h01 << ins[9:7])};
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #60000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      resetn_i = 1'b0;
      instr_valid_i = 1'b0;
      instr_i = 14'h0000;
      acc_m = 8'h00;
      flg = '0;
      b2b = 1'b0;
      for (int a = 0; a < 128; a++) begin
         rnd = nxt(rnd);
         fmem[a] = rnd[7:0];
      end
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      resetn_i = 1'b1;
      chk(16'(acc_o), 16'h0000);
      chk(16'(busy_o), 16'h0000);
      instr_i = pick(0, rnd);
      instr_valid_i = 1'b1;
      for (int i = 0; i < 80; i++) begin
         cur = instr_i;
         if (!b2b) @(posedge sys_clk_i);
         // junk while busy must be ignored
         repeat (3) begin
            @(negedge sys_clk_i);
            rnd = nxt(rnd);
            instr_i = rnd[13:0];
         end
         expect_op(cur);
         chk(16'(done_o), 16'h0000);
         chk(16'(busy_o), 16'h0001);
         chk(16'(file_addr_o), 16'(cur[6:0]));
         @(negedge sys_clk_i);
         rnd = nxt(rnd);
         b2b = (rnd[4:3] != 2'h0);
         instr_valid_i = b2b;
         instr_i = pick(i + 1, rnd);
         @(posedge sys_clk_i);
         #1;
         chk(16'(done_o), 16'h0001);
         chk(16'(busy_o), 16'(b2b));
         chk(16'(acc_o), 16'(ea));
         chk(16'(flags_we_o), 16'(efw));
         if (efw) chk(16'(flags_o), 16'(ef));
         chk(16'(file_wr_o.we), 16'(ew.we));
         if (ew.we) chk(16'(file_wr_o), 16'(ew));
         acc_m = ea;
         if (efw) flg = ef;
         $display("op %0d instr %h done", i, cur);
         if (!b2b) begin
            @(negedge sys_clk_i);
            instr_valid_i = 1'b1;
         end
      end
      tally_and_finish();
   end
endmodule
